// ---- core/cmm_regs.svh ----
`ifndef CMM_REGS_SVH
`define CMM_REGS_SVH

`define CMM_PADDR_W 23
`define CMM_DADDR_W 24
`define CMM_RESET_PC 23'h00_0000
`define CMM_DIRECT_IO_LAST 24'h00_003F
`define CMM_IO_LAST 24'h00_0FFF
`define CMM_NVM_FIRST 24'h00_1000
`define CMM_NVM_LAST 24'h00_1FFF
`define CMM_SRAM_FIRST 24'h00_2000

`define CMM_OP_NOP 4'h0
`define CMM_OP_ALU_RR 4'h1
`define CMM_OP_ALU_R 4'h2
`define CMM_OP_LDI 4'h3
`define CMM_OP_SUBI 4'h4
`define CMM_OP_ANDI 4'h5
`define CMM_OP_ORI 4'h6
`define CMM_OP_MUL 4'h7
`define CMM_OP_LD 4'h8
`define CMM_OP_ST 4'h9
`define CMM_OP_IO 4'hA
`define CMM_OP_RJMP 4'hB
`define CMM_OP_BRZ 4'hC
`define CMM_OP_PAGE 4'hD
`define CMM_OP_SELFPROG 4'hE

`define CMM_PTR_X 5'h1A
`define CMM_PTR_Y 5'h1C
`define CMM_PTR_Z 5'h1E
`define CMM_PTR_HI 5'h01
`define CMM_FLAG_C 0
`define CMM_FLAG_Z 1
`define CMM_FLAG_N 2
`define CMM_FLAG_V 3

`endif

// ---- core/cmm_pkg.sv ----
package cmm_pkg;
    typedef enum logic [1:0] {
        cmm_st_run = 2'h0,
        cmm_st_load = 2'h1,
        cmm_st_mul = 2'h2
    } cmm_state_type;

    typedef enum logic [3:0] {
        cmm_alu_add = 4'h0,
        cmm_alu_sub = 4'h1,
        cmm_alu_and = 4'h2,
        cmm_alu_or = 4'h3,
        cmm_alu_inc = 4'h4,
        cmm_alu_dec = 4'h5,
        cmm_alu_com = 4'h6,
        cmm_alu_lsr = 4'h7,
        cmm_alu_pass = 4'h8
    } cmm_alu_op_type;
endpackage

// ---- core/cmm_alu_if.sv ----
`timescale 1ns/1ps
interface cmm_alu_if;
    import cmm_pkg::*;
    cmm_alu_op_type alu_op;
    logic [7:0] a;
    logic [7:0] b;
    logic cin;
    logic [7:0] res;
    logic c_out;
    logic v_out;
    logic mul_start;
    logic mul_done;
    logic [15:0] prod;
    modport core (output alu_op, a, b, cin, mul_start, input res, c_out, v_out, mul_done, prod);
    modport alu (input alu_op, a, b, cin, mul_start, output res, c_out, v_out, mul_done, prod);
endinterface

// ---- core/cmm_alu.sv ----
`timescale 1ns/1ps
module cmm_alu import cmm_pkg::*; (
    input wire logic clock,
    input wire logic rst_n,
    cmm_alu_if.alu bus
);
    logic [7:0] mul_a_q;
    logic [7:0] mul_b_q;
    logic mul_busy_q;
    logic [8:0] wide;

    // single-cycle arithmetic and logic on the two operands
    always_comb begin
        wide = 9'h000;
        bus.res = 8'h00;
        bus.c_out = bus.cin;
        bus.v_out = 1'b0;
        unique case (bus.alu_op)
            cmm_alu_add: begin
                wide = {1'b0, bus.a} + {1'b0, bus.b};
                bus.res = wide[7:0];
                bus.c_out = wide[8];
                bus.v_out = (bus.a[7] == bus.b[7]) && (wide[7] != bus.a[7]);
            end
            cmm_alu_sub: begin
                wide = {1'b0, bus.a} - {1'b0, bus.b};
                bus.res = wide[7:0];
                bus.c_out = wide[8];
                bus.v_out = (bus.a[7] != bus.b[7]) && (wide[7] != bus.a[7]);
            end
            cmm_alu_and: bus.res = bus.a & bus.b;
            cmm_alu_or: bus.res = bus.a | bus.b;
            cmm_alu_inc: begin
                bus.res = bus.a + 8'h01;
                bus.v_out = (bus.a == 8'h7F);
            end
            cmm_alu_dec: begin
                bus.res = bus.a - 8'h01;
                bus.v_out = (bus.a == 8'h80);
            end
            cmm_alu_com: begin
                bus.res = ~bus.a;
                bus.c_out = 1'b1;
            end
            cmm_alu_lsr: begin
                bus.res = {1'b0, bus.a[7:1]};
                bus.c_out = bus.a[0];
                bus.v_out = bus.a[0]; // n is always clear, so v = n ^ c = c
            end
            cmm_alu_pass: bus.res = bus.b;
            default: bus.res = 8'h00; // spare op codes give zero
        endcase
    end

    // operands captured on the issue edge, product ready in the second cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mul_a_q <= 8'h00;
            mul_b_q <= 8'h00;
            mul_busy_q <= 1'b0;
        end else begin
            mul_busy_q <= bus.mul_start;
            if (bus.mul_start) begin
                mul_a_q <= bus.a;
                mul_b_q <= bus.b;
            end
        end
    end

    assign bus.mul_done = mul_busy_q;
    assign bus.prod = 16'(mul_a_q) * 16'(mul_b_q);
endmodule

// ---- core/cmm_core.sv ----
`timescale 1ns/1ps
`include "cmm_regs.svh"
module cmm_core import cmm_pkg::*; #(
    parameter logic [22:0] BOOT_START = 23'h01_0000,
    parameter logic [22:0] TABLE_START = 23'h00_E000
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [15:0] prog_data,
    input wire logic [7:0] data_rdata,
    input wire logic nvm_map_en,
    input wire logic app_wr_lock,
    input wire logic app_rw_lock,
    input wire logic tbl_wr_lock,
    input wire logic tbl_rw_lock,
    input wire logic boot_wr_lock,
    input wire logic boot_rw_lock,
    output logic prog_rd_q,
    output logic [22:0] prog_addr_q,
    output logic [23:0] data_addr_q,
    output logic [7:0] data_wdata_q,
    output logic data_rd_q,
    output logic data_wr_q,
    output logic io_sel_q,
    output logic nvm_sel_q,
    output logic sram_sel_q,
    output logic selfprog_wr_q,
    output logic [22:0] selfprog_addr_q,
    output logic [15:0] selfprog_data_q,
    output logic selfprog_refused_q
);
    logic rst_meta_q, rst_n_q, ir_valid_q, ld_live_q;
    cmm_state_type state_q;
    logic [22:0] ir_pc_q;
    logic [7:0] rf_q [32];
    logic [3:0] sreg_q;
    logic [7:0] page_q;
    logic [4:0] ld_dst_q;
    logic exec, in_io, in_nvm, in_sram, mem_live, sp_locked, sp_ok, rf_we;
    logic flag_we, jump, ld_go, st_go, mul_go, sp_go, ptr_inc, page_we;
    logic [15:0] ir, ptr_val;
    logic [3:0] opc;
    logic [4:0] rd_a, rr_a, imm_a, mem_a, ptr_a, rf_wa;
    logic [23:0] eff_addr;
    logic [22:0] off, jump_to, sp_tgt;

    cmm_alu_if alu_bus();
    cmm_alu u_alu (
        .clock(clock),
        .rst_n(rst_n_q),
        .bus(alu_bus)
    );

    // reset release through two flops so every flop leaves reset on the same edge
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // instruction fields; the word comes straight off the program bus
    assign ir = prog_data;
    assign opc = ir[15:12];
    assign rd_a = ir[9:5];
    assign rr_a = ir[4:0];
    assign imm_a = {1'b1, ir[11:8]};
    assign mem_a = (opc == `CMM_OP_IO) ? ir[4:0] : ir[9:5];
    assign exec = (state_q == cmm_st_run) && ir_valid_q;

    // pointer pairs: even register is the low byte
    always_comb begin
        unique case (ir[11:10])
            2'h0: ptr_a = `CMM_PTR_X;
            2'h1: ptr_a = `CMM_PTR_Y;
            default: ptr_a = `CMM_PTR_Z;
        endcase
    end
    assign ptr_val = {rf_q[ptr_a | `CMM_PTR_HI], rf_q[ptr_a]};

    // direct I/O form carries only six address bits, so it cannot reach extended I/O
    assign eff_addr = (opc == `CMM_OP_IO) ? {18'h0_0000, ir[10:5]} : {page_q, ptr_val};
    assign in_io = eff_addr <= `CMM_IO_LAST;
    assign in_nvm = (eff_addr >= `CMM_NVM_FIRST) && (eff_addr <= `CMM_NVM_LAST);
    assign in_sram = eff_addr >= `CMM_SRAM_FIRST;
    assign mem_live = !in_nvm || nvm_map_en;

    assign off = (opc == `CMM_OP_RJMP) ? {{11{ir[11]}}, ir[11:0]} : {{12{ir[10]}}, ir[10:0]};
    assign jump_to = ir_pc_q + 23'h00_0001 + off;

    // self-programming target is the Z word address; sections split by their starts
    assign sp_tgt = {7'h00, rf_q[`CMM_PTR_Z | `CMM_PTR_HI], rf_q[`CMM_PTR_Z]};
    always_comb begin
        if (sp_tgt >= BOOT_START) begin
            sp_locked = boot_wr_lock || boot_rw_lock;
        end else if (sp_tgt >= TABLE_START) begin
            sp_locked = tbl_wr_lock || tbl_rw_lock;
        end else begin
            sp_locked = app_wr_lock || app_rw_lock;
        end
    end
    assign sp_ok = (ir_pc_q >= BOOT_START) && !sp_locked;

    // instruction decode into control strobes
    always_comb begin
        alu_bus.alu_op = cmm_alu_pass;
        alu_bus.b = ir[7:0];
        rf_we = 1'b0;
        rf_wa = rd_a;
        flag_we = 1'b0;
        jump = 1'b0;
        ld_go = 1'b0;
        st_go = 1'b0;
        mul_go = 1'b0;
        sp_go = 1'b0;
        ptr_inc = 1'b0;
        page_we = 1'b0;
        if (exec) begin
            case (opc)
                `CMM_OP_ALU_RR: begin
                    alu_bus.alu_op = cmm_alu_op_type'({2'h0, ir[11:10]});
                    alu_bus.b = rf_q[rr_a];
                    rf_we = 1'b1;
                    flag_we = 1'b1;
                end
                `CMM_OP_ALU_R: begin
                    alu_bus.alu_op = cmm_alu_op_type'({2'h1, ir[11:10]});
                    rf_we = 1'b1;
                    flag_we = 1'b1;
                end
                `CMM_OP_LDI: begin
                    rf_wa = imm_a;
                    rf_we = 1'b1;
                end
                `CMM_OP_SUBI, `CMM_OP_ANDI, `CMM_OP_ORI: begin
                    alu_bus.alu_op = (opc == `CMM_OP_SUBI) ? cmm_alu_sub :
                                     (opc == `CMM_OP_ANDI) ? cmm_alu_and : cmm_alu_or;
                    rf_wa = imm_a;
                    rf_we = 1'b1;
                    flag_we = 1'b1;
                end
                `CMM_OP_MUL: begin
                    alu_bus.b = rf_q[rr_a];
                    mul_go = 1'b1;
                end
                `CMM_OP_LD: begin
                    ld_go = 1'b1;
                    ptr_inc = ir[0];
                end
                `CMM_OP_ST: begin
                    st_go = 1'b1;
                    ptr_inc = ir[0];
                end
                `CMM_OP_IO: begin
                    st_go = ir[11];
                    ld_go = !ir[11];
                end
                `CMM_OP_RJMP: jump = 1'b1;
                `CMM_OP_BRZ: jump = sreg_q[`CMM_FLAG_Z] ^ ir[11];
                `CMM_OP_PAGE: page_we = 1'b1;
                `CMM_OP_SELFPROG: sp_go = 1'b1;
                default: jump = 1'b0; // no-operation and spare codes
            endcase
        end
    end

    assign alu_bus.a = rf_q[rf_wa];
    assign alu_bus.cin = sreg_q[`CMM_FLAG_C];
    assign alu_bus.mul_start = mul_go;

    // fetch: program bus only; the next word is read while this one executes
    always_ff @(posedge clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            prog_rd_q <= 1'b0;
            prog_addr_q <= `CMM_RESET_PC;
            ir_pc_q <= `CMM_RESET_PC;
            ir_valid_q <= 1'b0;
        end else if (state_q == cmm_st_run) begin
            prog_rd_q <= 1'b1;
            if (jump) begin
                prog_addr_q <= jump_to; // prefetched word is dropped
                ir_valid_q <= 1'b0;
            end else begin
                ir_pc_q <= prog_addr_q;
                ir_valid_q <= 1'b1;
                if (!(ld_go || mul_go)) begin
                    prog_addr_q <= prog_addr_q + 23'h00_0001;
                end
            end
        end else if (state_q == cmm_st_load || alu_bus.mul_done) begin
            prog_addr_q <= prog_addr_q + 23'h00_0001; // held word is now in hand, so fetching moves on
        end
    end

    // wait states for load return and the second multiply cycle
    always_ff @(posedge clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q <= cmm_st_run;
            ld_dst_q <= 5'h00;
            ld_live_q <= 1'b0;
        end else begin
            unique case (state_q)
                cmm_st_run: begin
                    if (ld_go) begin
                        state_q <= cmm_st_load;
                        ld_dst_q <= mem_a;
                        ld_live_q <= mem_live;
                    end else if (mul_go) begin
                        state_q <= cmm_st_mul;
                    end
                end
                cmm_st_load: state_q <= cmm_st_run;
                cmm_st_mul: if (alu_bus.mul_done) state_q <= cmm_st_run;
            endcase
        end
    end

    // register file: one byte port for results, one pair port for pointers and products
    always_ff @(posedge clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            for (int i = 0; i < 32; i++) begin
                rf_q[i] <= 8'h00;
            end
        end else begin
            if (rf_we) rf_q[rf_wa] <= alu_bus.res;
            if (ptr_inc) begin
                {rf_q[ptr_a | `CMM_PTR_HI], rf_q[ptr_a]} <= ptr_val + 16'h0001;
            end
            if (state_q == cmm_st_load) begin
                rf_q[ld_dst_q] <= ld_live_q ? data_rdata : 8'h00;
            end
            if (state_q == cmm_st_mul && alu_bus.mul_done) begin
                {rf_q[1], rf_q[0]} <= alu_bus.prod;
            end
        end
    end

    // status flags follow the register and subtract/and/or immediate ALU results; load-immediate and multiply leave them
    always_ff @(posedge clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            sreg_q <= 4'h0;
        end else if (flag_we) begin
            sreg_q[`CMM_FLAG_C] <= alu_bus.c_out;
            sreg_q[`CMM_FLAG_Z] <= (alu_bus.res == 8'h00);
            sreg_q[`CMM_FLAG_N] <= alu_bus.res[7];
            sreg_q[`CMM_FLAG_V] <= alu_bus.v_out;
        end
    end

    // upper byte of data addresses for pointer forms
    always_ff @(posedge clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            page_q <= 8'h00;
        end else if (page_we) begin
            page_q <= ir[7:0];
        end
    end

    // data bus: runs beside the program bus; unmapped window access gives no strobe
    always_ff @(posedge clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            data_addr_q <= 24'h00_0000;
            data_wdata_q <= 8'h00;
            data_rd_q <= 1'b0;
            data_wr_q <= 1'b0;
            io_sel_q <= 1'b0;
            nvm_sel_q <= 1'b0;
            sram_sel_q <= 1'b0;
        end else begin
            data_rd_q <= ld_go && mem_live;
            data_wr_q <= st_go && mem_live;
            io_sel_q <= (ld_go || st_go) && in_io;
            nvm_sel_q <= (ld_go || st_go) && in_nvm && nvm_map_en;
            sram_sel_q <= (ld_go || st_go) && in_sram;
            if (ld_go || st_go) begin
                data_addr_q <= eff_addr;
                data_wdata_q <= rf_q[mem_a];
            end
        end
    end

    // self-programming request: honoured only from boot code on an unlocked section
    always_ff @(posedge clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            selfprog_wr_q <= 1'b0;
            selfprog_refused_q <= 1'b0;
            selfprog_addr_q <= 23'h00_0000;
            selfprog_data_q <= 16'h0000;
        end else begin
            selfprog_wr_q <= sp_go && sp_ok;
            selfprog_refused_q <= sp_go && !sp_ok;
            if (sp_go) begin
                selfprog_addr_q <= sp_tgt;
                selfprog_data_q <= {rf_q[1], rf_q[0]};
            end
        end
    end
endmodule

// ---- testbench/cmm_core_checker.sv ----
`timescale 1ns/1ps
module cmm_core_checker #(
    parameter logic [22:0] BOOT_START = 23'h01_0000,
    parameter logic [22:0] TABLE_START = 23'h00_E000
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic nvm_map_en,
    input wire logic app_wr_lock,
    input wire logic app_rw_lock,
    input wire logic prog_rd_q,
    input wire logic [22:0] prog_addr_q,
    input wire logic [23:0] data_addr_q,
    input wire logic data_rd_q,
    input wire logic data_wr_q,
    input wire logic io_sel_q,
    input wire logic nvm_sel_q,
    input wire logic sram_sel_q,
    input wire logic selfprog_wr_q,
    input wire logic [22:0] selfprog_addr_q,
    input wire logic selfprog_refused_q
);
    logic acc;
    logic [2:0] sel;
    // any data strobe, and the three region selects side by side
    assign acc = data_rd_q | data_wr_q;
    assign sel = {io_sel_q, nvm_sel_q, sram_sel_q};
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);

    chk_first_fetch: assert property ($rose(prog_rd_q) |-> prog_addr_q == 23'h00_0001)
        else $error("first fetch after reset not from address zero");
    chk_load_stall: assert property (data_rd_q |-> $stable(prog_addr_q))
        else $error("fetch address moved during load stall");
    chk_load_single: assert property (data_rd_q |=> !data_rd_q)
        else $error("load strobe longer than one cycle");
    chk_load_resume: assert property (data_rd_q |=> prog_addr_q == $past(prog_addr_q) + 23'h00_0001)
        else $error("fetch did not resume after load stall");
    chk_store_flow: assert property (data_wr_q |-> prog_addr_q == $past(prog_addr_q) + 23'h00_0001)
        else $error("fetch did not advance beside a store");
    chk_one_region: assert property (acc |-> $onehot(sel))
        else $error("data access without exactly one region select");
    chk_idle_region: assert property (!acc |-> sel == 3'h0)
        else $error("region select without a data strobe");
    chk_io_window: assert property (acc && data_addr_q <= 24'h00_0FFF |-> io_sel_q)
        else $error("low address not steered to io");
    chk_nvm_window: assert property (acc && data_addr_q >= 24'h00_1000 && data_addr_q <= 24'h00_1FFF
        |-> nvm_sel_q && $past(nvm_map_en))
        else $error("nonvolatile window access wrongly steered");
    chk_sram_window: assert property (acc && data_addr_q >= 24'h00_2000 |-> sram_sel_q)
        else $error("high address not steered to sram");
    chk_boot_only: assert property (selfprog_wr_q |-> $past(prog_addr_q) > BOOT_START)
        else $error("program write issued from outside the boot section");
    chk_app_locked: assert property (selfprog_wr_q && selfprog_addr_q < TABLE_START
        |-> !$past(app_wr_lock) && !$past(app_rw_lock))
        else $error("program write into locked application section");
    chk_sp_exclusive: assert property (selfprog_wr_q |-> !selfprog_refused_q)
        else $error("program write and refusal together");
endmodule

// ---- testbench/cmm_mem_model.sv ----
`timescale 1ns/1ps
module cmm_mem_model (
    input wire logic clock,
    input wire logic [22:0] prog_addr,
    output logic [15:0] prog_data,
    input wire logic [23:0] data_addr,
    input wire logic data_rd,
    input wire logic data_wr,
    input wire logic [7:0] data_wdata,
    output logic [7:0] data_rdata
);
    logic [15:0] prog_mem [0:255];
    logic [7:0] data_mem [0:255];
    logic [7:0] last_q = 8'hA5;
    // program port: registered on the fetch address, its own bus
    always @(posedge clock) begin
        prog_data <= prog_mem[prog_addr[7:0]];
    end
    // data port: read answers in the strobe cycle, idle bus shows the inverse of the last read
    assign data_rdata = data_rd ? data_mem[data_addr[7:0]] : ~last_q;
    always @(posedge clock) begin
        if (data_rd) begin
            last_q <= data_mem[data_addr[7:0]];
        end
        if (data_wr) begin
            data_mem[data_addr[7:0]] <= data_wdata;
        end
    end
endmodule

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
`define CMM_CHECK(what, exp, got) begin checks++; if ((got) !== (exp)) begin errors++; \
    $display("unexpected %s expected %0h seen %0h", what, exp, got); end end
module testbench;
    localparam logic [22:0] BOOT = 23'h00_0040;
    localparam logic [22:0] TBL = 23'h00_0020;
    localparam logic [2:0] SR = 3'h1;
    localparam logic [39:0] ROWS [11] = '{40'h12_113C_0F4B, 40'h16_1110_010F, 40'h1A_11F0_3C30,
        40'h1E_11A0_05A5, 40'h22_00FF_0000, 40'h26_0000_00FF, 40'h2A_005A_00A5, 40'h2E_0081_0040,
        40'h40_2120_21FF, 40'h50_0FCC_0F0C, 40'h60_8011_8091};
    localparam logic [26:0] REG [8] = '{27'h400_003F, 27'h400_003F, 27'h400_0040, 27'h400_0FFF,
        27'h200_1000, 27'h200_1FFF, 27'h100_2000, 27'h1FF_FFFF};
    localparam logic [22:0] TGT [3] = '{23'h00_0010, 23'h00_0020, 23'h00_0048};
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic nvm_map_en = 1'b0;
    logic [5:0] lk = 6'h00;
    logic [15:0] prog_data;
    logic [7:0] data_rdata;
    logic prog_rd_q, data_rd_q, data_wr_q, io_sel_q, nvm_sel_q, sram_sel_q, selfprog_wr_q, selfprog_refused_q;
    logic [22:0] prog_addr_q;
    logic [22:0] selfprog_addr_q;
    logic [23:0] data_addr_q;
    logic [7:0] data_wdata_q;
    logic [15:0] selfprog_data_q;
    logic [34:0] st_q[$];
    logic [39:0] sp_q[$];
    logic [39:0] g;
    int errors = 0;
    int checks = 0;
    int pw;

    // 40 MHz clock
    always #12.5 clock = ~clock;

    cmm_core #(.BOOT_START(BOOT), .TABLE_START(TBL)) i_dut (.clock(clock), .nrst(nrst), .prog_data(prog_data),
        .data_rdata(data_rdata), .nvm_map_en(nvm_map_en), .app_wr_lock(lk[5]), .app_rw_lock(lk[4]),
        .tbl_wr_lock(lk[3]), .tbl_rw_lock(lk[2]), .boot_wr_lock(lk[1]), .boot_rw_lock(lk[0]),
        .prog_rd_q(prog_rd_q), .prog_addr_q(prog_addr_q), .data_addr_q(data_addr_q), .data_wdata_q(data_wdata_q),
        .data_rd_q(data_rd_q), .data_wr_q(data_wr_q), .io_sel_q(io_sel_q), .nvm_sel_q(nvm_sel_q),
        .sram_sel_q(sram_sel_q), .selfprog_wr_q(selfprog_wr_q), .selfprog_addr_q(selfprog_addr_q),
        .selfprog_data_q(selfprog_data_q), .selfprog_refused_q(selfprog_refused_q));
    cmm_mem_model i_mem (.clock(clock), .prog_addr(prog_addr_q), .prog_data(prog_data), .data_addr(data_addr_q),
        .data_rd(data_rd_q), .data_wr(data_wr_q), .data_wdata(data_wdata_q), .data_rdata(data_rdata));

    // record every store and every self-program outcome as it leaves the core
    always @(posedge clock) begin
        if (data_wr_q) begin
            st_q.push_back({io_sel_q, nvm_sel_q, sram_sel_q, data_addr_q, data_wdata_q});
        end
        if (selfprog_wr_q | selfprog_refused_q) begin
            sp_q.push_back({selfprog_refused_q, selfprog_addr_q, selfprog_data_q});
        end
    end

    function automatic logic [15:0] ldi(input logic [4:0] d, input logic [7:0] k);
        return {4'h3, d[3:0], k};
    endfunction

    task automatic emit(input logic [15:0] w);
        i_mem.prog_mem[pw] = w;
        pw++;
    endtask

    // a pointer pair is loaded low byte first into the even register
    task automatic ptr(input logic [4:0] r, input logic [15:0] v);
        emit(ldi(r, v[7:0]));
        emit(ldi(r + 5'd1, v[15:8]));
    endtask

    // hold reset and clear program memory, so each program starts from a known image
    task automatic prep();
        @(posedge clock);
        nrst <= 1'b0;
        @(posedge clock);
        for (int i = 0; i < 256; i++) begin
            i_mem.prog_mem[i] = 16'h0000;
        end
        pw = 0;
    endtask

    task automatic go(input int n);
        repeat (16) @(posedge clock);
        st_q.delete();
        sp_q.delete();
        nrst <= 1'b1;
        repeat (n) @(posedge clock);
    endtask

    task automatic take_st(input logic [34:0] e);
        logic [34:0] s;
        s = (st_q.size() > 0) ? st_q.pop_front() : 35'h0;
        `CMM_CHECK("store", e, s)
    endtask

    task automatic take_sp();
        g = (sp_q.size() > 0) ? sp_q.pop_front() : 40'h0;
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        // one program per row: operate, store, then store again only when the result was not zero
        foreach (ROWS[i]) begin
            prep();
            emit(ldi(5'd16, ROWS[i][23:16]));
            emit(ldi(5'd17, ROWS[i][15:8]));
            ptr(5'd26, 16'h2000);
            emit(ROWS[i][39:24]);
            emit(16'h9200);
            emit(16'hC001);
            emit(16'h9200);
            emit(16'hBFFF);
            go(30);
            take_st({SR, 24'h00_2000, ROWS[i][7:0]});
            if (ROWS[i][7:0] != 8'h00) take_st({SR, 24'h00_2000, ROWS[i][7:0]});
            `CMM_CHECK("row store count", 0, st_q.size())
        end
        // region edges through all pointers and the page, with and without the nonvolatile mapping
        for (int m = 1; m >= 0; m--) begin
            prep();
            `CMM_CHECK("fetch in reset", 24'h00_0000, {prog_rd_q, prog_addr_q})
            nvm_map_en <= m[0];
            emit(16'h3077);
            emit(16'hAFF0);
            ptr(5'd26, 16'h003F);
            emit(16'h9201);
            emit(16'h9200);
            ptr(5'd28, 16'h0FFF);
            emit(16'h9600);
            ptr(5'd30, 16'h1000);
            emit(16'h9A00);
            ptr(5'd30, 16'h1FFF);
            emit(16'h9A00);
            ptr(5'd30, 16'h2000);
            emit(16'h9A00);
            emit(16'hD0FF);
            ptr(5'd30, 16'hFFFF);
            emit(16'h9A00);
            emit(16'hBFFF);
            go(50);
            foreach (REG[i]) if (m == 1 || REG[i][26:24] != 3'h2) take_st({REG[i], 8'h77});
            `CMM_CHECK("region store count", 0, st_q.size())
        end
        // store, back-to-back loads, multiply straight into a store, and an unmapped window load
        prep();
        emit(16'h305A);
        ptr(5'd26, 16'h2000);
        emit(16'h9200);
        emit(16'h8240);
        emit(16'h8260);
        emit(16'h7253);
        emit(16'h9001);
        emit(16'h9020);
        ptr(5'd30, 16'h1000);
        emit(16'h8A80);
        ptr(5'd28, 16'h2010);
        emit(16'h9680);
        emit(16'hBFFF);
        go(40);
        take_st({SR, 24'h00_2000, 8'h5A});
        take_st({SR, 24'h00_2000, 8'hA4});
        take_st({SR, 24'h00_2001, 8'h1F});
        take_st({SR, 24'h00_2010, 8'h00});
        // self-programming from outside and inside the boot section, each lock on its own
        for (int k = 0; k < 7; k++) begin
            prep();
            lk <= (k == 0) ? 6'h00 : 6'h01 << (6 - k);
            emit(16'h3012);
            emit(16'h3134);
            emit(16'h7211);
            ptr(5'd30, 16'h0010);
            emit(16'hE000);
            emit(16'hB039);
            pw = 64;
            emit(16'hE000);
            ptr(5'd30, 16'h0020);
            emit(16'hE000);
            ptr(5'd30, 16'h0048);
            emit(16'hE000);
            emit(16'hBFFF);
            go(50);
            take_sp();
            `CMM_CHECK("refused outside boot", 1'b1, g[39])
            for (int j = 0; j < 3; j++) begin
                take_sp();
                if (lk[5 - 2 * j] | lk[4 - 2 * j]) `CMM_CHECK("locked", 1'b1, g[39])
                else `CMM_CHECK("program write", {1'b0, TGT[j], 16'h03A8}, g)
            end
        end
        summarize();
    end
endmodule

bind cmm_core cmm_core_checker #(.BOOT_START(BOOT_START), .TABLE_START(TABLE_START)) i_chk (.clock(clock),
    .nrst(nrst), .nvm_map_en(nvm_map_en), .app_wr_lock(app_wr_lock), .app_rw_lock(app_rw_lock),
    .prog_rd_q(prog_rd_q), .prog_addr_q(prog_addr_q), .data_addr_q(data_addr_q), .data_rd_q(data_rd_q),
    .data_wr_q(data_wr_q), .io_sel_q(io_sel_q), .nvm_sel_q(nvm_sel_q), .sram_sel_q(sram_sel_q),
    .selfprog_wr_q(selfprog_wr_q), .selfprog_addr_q(selfprog_addr_q), .selfprog_refused_q(selfprog_refused_q));
